// *** verilog/dsss_pkg.sv ***
// constants, types and helpers for the seek and sector search sequencer
`default_nettype none
package dsss_pkg;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned SETTLE_MS  = 15;
  localparam int unsigned RATE0_MS   = 3;
  localparam int unsigned RATE1_MS   = 6;
  localparam int unsigned RATE2_MS   = 10;
  localparam int unsigned RATE3_MS   = 15;
  localparam int unsigned STEP_PW_US = 4;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_PW_CYC = STEP_PW_US * (CLK_HZ / 1_000_000);
  // register byte offsets
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_TRACK  = 5'h04;
  localparam logic [4:0] REG_SECTOR = 5'h08;
  localparam logic [4:0] REG_DATA   = 5'h0c;
  localparam logic [4:0] REG_CFG    = 5'h10;
  // status bit positions
  localparam int ST_BUSY   = 0;
  localparam int ST_TRK0   = 2;
  localparam int ST_CRC    = 3;
  localparam int ST_SEEK   = 4;
  localparam int ST_HEAD   = 5;
  localparam int ST_NOTRDY = 7;
  // command fields
  localparam logic [2:0] OP_RESTSEEK = 3'h0;
  localparam logic [2:0] OP_STEP     = 3'h1;
  localparam logic [2:0] OP_IN       = 3'h2;
  localparam logic [2:0] OP_OUT      = 3'h3;
  localparam logic [2:0] OP_RDSEC    = 3'h4;
  localparam logic [2:0] OP_WRSEC    = 3'h5;
  localparam logic [3:0] OP_FORCE    = 4'hd;
  localparam int F_SEEK   = 4;
  localparam int F_UPDATE = 4;
  localparam int F_MULTI  = 4;
  localparam int F_HEAD   = 3;
  localparam int F_BIT3   = 3;
  localparam int F_VERIFY = 2;
  localparam int F_DELAY  = 2;
  localparam int F_BIT1   = 1;
  localparam int CFG_SIDEOUT = 8;
  localparam logic [7:0] RESTORE_CMD = 8'h03;
  localparam logic [8:0] CFG_RST     = 9'h01a;
  localparam logic [3:0] IDLE_REVS   = 4'hf;
  localparam logic [2:0] SEARCH_REVS = 3'h4;
  localparam logic [2:0] SIDE_REVS   = 3'h5;
  localparam logic [7:0] RESTORE_MAX = 8'hff;
  localparam logic [7:0] INNER_TRACK = 8'h2b;

  typedef enum {S_IDLE, S_START, S_PULSE, S_RATE, S_VCHK, S_SETTLE,
                S_HLT, S_SCAN, S_XFER} dsss_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] track;
    logic       side;
    logic [7:0] sector;
    logic [1:0] len;
    logic       crc_ok;
  } dsss_id_s;

  // length code to byte count, two tables selected by map
  function automatic logic [10:0] dsss_len(input logic map,
                                           input logic [1:0] code);
    logic [1:0] c;
    c = map ? code : code + 2'h1;
    dsss_len = 11'h080 << c;
  endfunction : dsss_len
endpackage : dsss_pkg
`default_nettype wire

// *** verilog/dsss_top.sv ***
// seek, step and sector search command sequencer with avalon registers
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - positioning command loads head when h is one, unloads it when zero.
// - head stays loaded; after 15 idle revolutions it unloads itself.
// - verify loads head, waits 15 ms, waits settled, then reads IDs.
// - verify track match with good crc completes, interrupts, clears busy.
// - good crc but track mismatch sets seek error bit 4 and ends.
// - track match with bad crc sets crc bit 3 and tries next ID.
// - no good ID in four revolutions ends verify with interrupt.
// - step commands move track register by one only when update set.
// - restore steps until track zero, then clears track and interrupts.
// - no track zero after 255 pulses sets seek error and ends.
// - master reset going inactive runs a restore.
// - seek steps toward data register, updating track, until equal.
// - step pulses once in previous direction, waits, verifies, interrupts.
// - step-in goes toward 76 and increments; step-out toward 0.
// - sector command sets busy, loads head, optional 15 ms settle.
// - search compares track then sector, needs good crc to proceed.
// - no matching ID in four revolutions (five with side test) sets failure bit and ends.
// - multi flag loops sectors, incrementing, until count exceeded or force.
// - sector register beyond sectors per track sets record-not-found; the code compares it only after the multi-sector increment.
// - side test compares ID side to expected bit within 5 index pulses.
// - length code decodes to 128 up to 1024 bytes per selected table.
// - side-output mode drives side pin from flag; type one leaves it.
// - busy while running; finish raises interrupt and clears busy.
// - sector command samples ready and updates inner track output.
module dsss_top import dsss_pkg::*; #(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RATE0_CYCLES  = RATE0_MS * (CLK_HZ / 1000),
  parameter int unsigned RATE1_CYCLES  = RATE1_MS * (CLK_HZ / 1000),
  parameter int unsigned RATE2_CYCLES  = RATE2_MS * (CLK_HZ / 1000),
  parameter int unsigned RATE3_CYCLES  = RATE3_MS * (CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // drive side
  input  wire logic        master_reset_in,
  input  wire logic        head_settled_in,
  input  wire logic        track_zero_in,
  input  wire logic        drive_ready_i,
  input  wire logic        index_i,
  output logic             head_engage_out,
  output logic             step_o,
  output logic             step_dir_o,
  output logic             side_output_pin,
  output logic             inner_track_out,
  output logic             interrupt_request,
  // id field decoder and data field engine
  input  wire dsss_id_s    id_i,
  input  wire logic        data_done_i,
  output logic             data_go_o,
  output logic      [10:0] sector_bytes_o
);
  dsss_state_e state_q;
  logic [7:0]  cmd_q, track_q, sector_q, data_q, pulses_q;
  logic [8:0]  cfg_q;
  logic [18:0] timer_q;
  logic [2:0]  rev_q;
  logic [3:0]  idle_rev_q;
  logic        busy_q, crc_q, seek_q, notrdy_q, irq_q, head_q;
  logic        step_q, dir_q, side_q, inner_q, go_q;
  logic [10:0] bytes_q;
  logic        wait_q, mr_q, idx_q;
  logic [31:0] rdata_q;

  logic        req, bus_wr, bus_rd, cmd_wr, force_wr, stat_rd;
  logic        mr_fall, idx_rise, type1, sideout, side_test;
  logic        side_ok, track_eq, sector_eq;
  logic [2:0]  op, rev_limit;
  logic [7:0]  status, next_sec;
  logic [18:0] rate_cyc;

  assign req      = avs_read_i | avs_write_i;
  assign bus_wr   = avs_write_i & ~wait_q;
  assign bus_rd   = avs_read_i & ~wait_q;
  assign cmd_wr   = bus_wr & (avs_address_i == REG_CMD);
  assign force_wr = cmd_wr & (avs_writedata_i[7:4] == OP_FORCE);
  assign stat_rd  = bus_rd & (avs_address_i == REG_CMD);
  assign mr_fall  = mr_q & ~master_reset_in;
  assign idx_rise = index_i & ~idx_q;
  assign op       = cmd_q[7:5];
  assign type1    = ~cmd_q[7];
  assign sideout  = cfg_q[CFG_SIDEOUT];
  // side compare only without side-output mode
  assign side_test = ~type1 & ~sideout & cmd_q[F_BIT1];
  assign side_ok   = ~side_test | (id_i.side == cmd_q[F_BIT3]);
  assign track_eq  = id_i.track == track_q;
  assign sector_eq = id_i.sector == sector_q;
  assign next_sec  = sector_q + 8'h01;
  // side test widens the search window
  assign rev_limit = side_test ? SIDE_REVS : SEARCH_REVS;
  assign status    = {notrdy_q, 1'b0, head_q, seek_q, crc_q,
                      ~track_zero_in, 1'b0, busy_q};

  always_comb begin
    case (cmd_q[1:0])
      2'h0:    rate_cyc = 19'(RATE0_CYCLES - 1);
      2'h1:    rate_cyc = 19'(RATE1_CYCLES - 1);
      2'h2:    rate_cyc = 19'(RATE2_CYCLES - 1);
      default: rate_cyc = 19'(RATE3_CYCLES - 1);
    endcase
  end

  // bus slave: one wait cycle, then completion
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (avs_read_i & wait_q) begin
        case (avs_address_i)
          REG_CMD:    rdata_q <= {24'h0, status};
          REG_TRACK:  rdata_q <= {24'h0, track_q};
          REG_SECTOR: rdata_q <= {24'h0, sector_q};
          REG_DATA:   rdata_q <= {24'h0, data_q};
          REG_CFG:    rdata_q <= {23'h0, cfg_q};
          default:    rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // edge history of master reset and index
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mr_q  <= 1'b0;
      idx_q <= 1'b0;
    end else begin
      mr_q  <= master_reset_in;
      idx_q <= index_i;
    end
  end

  // command sequencer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q    <= S_IDLE;
      cmd_q      <= 8'h0;
      track_q    <= 8'h0;
      sector_q   <= 8'h0;
      data_q     <= 8'h0;
      cfg_q      <= CFG_RST;
      pulses_q   <= 8'h0;
      timer_q    <= 19'h0;
      rev_q      <= 3'h0;
      idle_rev_q <= 4'h0;
      busy_q     <= 1'b0;
      crc_q      <= 1'b0;
      seek_q     <= 1'b0;
      notrdy_q   <= 1'b0;
      irq_q      <= 1'b0;
      head_q     <= 1'b0;
      step_q     <= 1'b0;
      dir_q      <= 1'b0;
      side_q     <= 1'b0;
      inner_q    <= 1'b0;
      go_q       <= 1'b0;
      bytes_q    <= 11'h0;
    end else begin
      go_q <= 1'b0;
      if (stat_rd)
        irq_q <= 1'b0;
      if (bus_wr) begin
        case (avs_address_i)
          REG_TRACK:  track_q  <= avs_writedata_i[7:0];
          REG_SECTOR: sector_q <= avs_writedata_i[7:0];
          REG_DATA:   data_q   <= avs_writedata_i[7:0];
          REG_CFG:    cfg_q    <= avs_writedata_i[8:0];
          default:    ;
        endcase
      end
      if (idx_rise && state_q != S_IDLE && rev_q != 3'h7)
        rev_q <= rev_q + 3'h1;
      case (state_q)
        S_IDLE: begin
          if (idx_rise && head_q) begin
            if (idle_rev_q == IDLE_REVS - 4'h1)
              head_q <= 1'b0;
            else
              idle_rev_q <= idle_rev_q + 4'h1;
          end
          if (force_wr) begin
            irq_q <= |avs_writedata_i[3:0];
          end else if (mr_fall || cmd_wr) begin
            cmd_q    <= mr_fall ? RESTORE_CMD : avs_writedata_i[7:0];
            busy_q   <= 1'b1;
            irq_q    <= 1'b0;
            crc_q    <= 1'b0;
            seek_q   <= 1'b0;
            notrdy_q <= 1'b0;
            pulses_q <= 8'h0;
            state_q  <= S_START;
          end
        end
        S_START: begin
          if (type1) begin
            head_q <= cmd_q[F_HEAD];
            case (op)
              OP_RESTSEEK: begin
                if (!cmd_q[F_SEEK]) begin
                  if (!track_zero_in) begin
                    track_q <= 8'h0;
                    state_q <= S_VCHK;
                  end else begin
                    dir_q   <= 1'b0;
                    state_q <= S_PULSE;
                  end
                end else if (track_q == data_q) begin
                  state_q <= S_VCHK;
                end else begin
                  dir_q   <= data_q > track_q;
                  state_q <= S_PULSE;
                end
              end
              OP_STEP: state_q <= S_PULSE;
              OP_IN: begin
                dir_q   <= 1'b1;
                state_q <= S_PULSE;
              end
              default: begin
                dir_q   <= 1'b0;
                state_q <= S_PULSE;
              end
            endcase
          end else if (op == OP_RDSEC || op == OP_WRSEC) begin
            // ready check and inner track update
            inner_q <= track_q > INNER_TRACK;
            if (!drive_ready_i) begin
              notrdy_q <= 1'b1;
              busy_q   <= 1'b0;
              irq_q    <= 1'b1;
              state_q  <= S_IDLE;
            end else begin
              head_q <= 1'b1;
              if (sideout)
                side_q <= cmd_q[F_BIT1];
              timer_q <= cmd_q[F_DELAY] ? 19'(SETTLE_CYCLES - 1) : 19'h0;
              state_q <= S_SETTLE;
            end
          end else begin
            busy_q  <= 1'b0;
            irq_q   <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_PULSE: begin
          if (!step_q) begin
            step_q   <= 1'b1;
            timer_q  <= 19'(STEP_PW_CYC - 1);
            pulses_q <= pulses_q + 8'h01;
            // track follows each pulse when enabled
            if ((op == OP_RESTSEEK && cmd_q[F_SEEK]) ||
                (op != OP_RESTSEEK && cmd_q[F_UPDATE]))
              track_q <= dir_q ? track_q + 8'h01 : track_q - 8'h01;
          end else if (timer_q != 19'h0) begin
            timer_q <= timer_q - 19'h1;
          end else begin
            step_q  <= 1'b0;
            timer_q <= rate_cyc;
            state_q <= S_RATE;
          end
        end
        S_RATE: begin
          if (timer_q != 19'h0) begin
            timer_q <= timer_q - 19'h1;
          end else if (op == OP_RESTSEEK && !cmd_q[F_SEEK]) begin
            if (!track_zero_in) begin
              track_q <= 8'h0;
              state_q <= S_VCHK;
            // give up after the last pulse
            end else if (pulses_q == RESTORE_MAX) begin
              seek_q  <= 1'b1;
              busy_q  <= 1'b0;
              irq_q   <= 1'b1;
              state_q <= S_IDLE;
            end else begin
              state_q <= S_PULSE;
            end
          end else if (op == OP_RESTSEEK && track_q != data_q) begin
            state_q <= S_PULSE;
          end else begin
            state_q <= S_VCHK;
          end
        end
        S_VCHK: begin
          if (cmd_q[F_VERIFY]) begin
            head_q  <= 1'b1;
            timer_q <= 19'(SETTLE_CYCLES - 1);
            state_q <= S_SETTLE;
          end else begin
            busy_q  <= 1'b0;
            irq_q   <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        // settle delay then wait for head settled
        S_SETTLE: begin
          if (timer_q != 19'h0)
            timer_q <= timer_q - 19'h1;
          else
            state_q <= S_HLT;
        end
        S_HLT: begin
          if (head_settled_in) begin
            rev_q   <= 3'h0;
            state_q <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (rev_q >= (type1 ? SEARCH_REVS : rev_limit)) begin
            seek_q  <= ~type1;
            busy_q  <= 1'b0;
            irq_q   <= 1'b1;
            state_q <= S_IDLE;
          end else if (id_i.valid && type1) begin
            if (track_eq && id_i.crc_ok) begin
              busy_q  <= 1'b0;
              irq_q   <= 1'b1;
              state_q <= S_IDLE;
            end else if (id_i.crc_ok) begin
              seek_q  <= 1'b1;
              busy_q  <= 1'b0;
              irq_q   <= 1'b1;
              state_q <= S_IDLE;
            end else if (track_eq) begin
              crc_q <= 1'b1;
            end
          // track, sector, side and crc must all match
          end else if (id_i.valid && track_eq && sector_eq && side_ok) begin
            if (id_i.crc_ok) begin
              go_q    <= 1'b1;
              bytes_q <= dsss_len(sideout ? cmd_q[F_BIT3] : 1'b1, id_i.len);
              state_q <= S_XFER;
            end else begin
              crc_q <= 1'b1;
            end
          end
        end
        S_XFER: begin
          if (data_done_i) begin
            if (cmd_q[F_MULTI]) begin
              sector_q <= next_sec;
              rev_q    <= 3'h0;
              if (next_sec > cfg_q[7:0]) begin
                seek_q  <= 1'b1;
                busy_q  <= 1'b0;
                irq_q   <= 1'b1;
                state_q <= S_IDLE;
              end else begin
                state_q <= S_SCAN;
              end
            end else begin
              busy_q  <= 1'b0;
              irq_q   <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
      // force interrupt ends a running command
      if (force_wr && state_q != S_IDLE) begin
        step_q  <= 1'b0;
        busy_q  <= 1'b0;
        irq_q   <= 1'b1;
        state_q <= S_IDLE;
      end
      if (state_q != S_IDLE)
        idle_rev_q <= 4'h0;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign head_engage_out   = head_q;
  assign step_o            = step_q;
  assign step_dir_o        = dir_q;
  assign side_output_pin   = side_q;
  assign inner_track_out   = inner_q;
  assign interrupt_request = irq_q;
  assign data_go_o         = go_q;
  assign sector_bytes_o    = bytes_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  head_flag_start_a: assert property (
    state_q == S_START && type1 |=> head_q == $past(cmd_q[F_HEAD]))
    else $error("head not set from flag at start");
  busy_fall_irq_a: assert property (
    $fell(busy_q) |-> irq_q && state_q == S_IDLE)
    else $error("busy cleared without interrupt");
  restore_limit_a: assert property (
    state_q == S_RATE && timer_q == 19'h0 && op == OP_RESTSEEK &&
    !cmd_q[F_SEEK] && track_zero_in && pulses_q == RESTORE_MAX
    |=> seek_q && !busy_q)
    else $error("restore did not stop at pulse limit");
  restore_zero_a: assert property (
    state_q == S_START && type1 && op == OP_RESTSEEK && !cmd_q[F_SEEK]
    && !track_zero_in |=> track_q == 8'h0 && state_q == S_VCHK)
    else $error("restore at track zero mishandled");
  step_noupd_a: assert property (
    state_q == S_PULSE && !step_q && op != OP_RESTSEEK &&
    !cmd_q[F_UPDATE] |=> $stable(track_q))
    else $error("track changed without update flag");
  step_in_a: assert property (
    state_q == S_START && op == OP_IN && cmd_q[F_UPDATE]
    |=> dir_q ##1 track_q == $past(track_q, 2) + 8'h01)
    else $error("step-in did not advance track");
  mr_restore_a: assert property (
    state_q == S_IDLE && mr_fall && !force_wr
    |=> state_q == S_START && cmd_q == RESTORE_CMD && busy_q)
    else $error("no restore after master reset");
  not_ready_a: assert property (
    state_q == S_START && !type1 && (op == OP_RDSEC || op == OP_WRSEC)
    && !drive_ready_i |=> notrdy_q && irq_q && !busy_q && !go_q)
    else $error("not-ready sector command ran");
  go_match_a: assert property (
    go_q |-> $past(id_i.valid && id_i.crc_ok && track_eq && sector_eq))
    else $error("data field started on wrong ID");
  seek_err_a: assert property (
    state_q == S_SCAN && type1 && id_i.valid && id_i.crc_ok && !track_eq
    && rev_q < SEARCH_REVS && !force_wr |=> seek_q && !busy_q)
    else $error("track mismatch not flagged");
  step_width_a: assert property (
    $rose(step_o) |-> step_o [*8])
    else $error("step pulse too short");
endmodule : dsss_top
`default_nettype wire

// *** dv/dsss_drive_model.sv ***
// drive model: head position, index pulses and id fields
`timescale 1ns/1ps
`default_nettype none
module dsss_drive_model import dsss_pkg::*; (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // from controller
  input  wire logic step_o,
  input  wire logic step_dir_o,
  input  wire logic head_engage_out,
  // from bench: sensor held off track zero
  input  wire logic trk0_stuck_i,
  // to controller
  output logic      head_settled_in,
  output logic      track_zero_in,
  output logic      index_i,
  output var dsss_id_s id_i
);
  logic [7:0] pos_q;
  logic [7:0] sec_q;
  logic [5:0] cnt_q;
  logic       step_q;
  logic       v;
  assign v = head_engage_out && cnt_q == 6'h27;
  assign head_settled_in = head_engage_out;
  // sensor is low only over track zero, unless held stuck
  assign track_zero_in = pos_q != 8'h00 || trk0_stuck_i;
  assign index_i = sec_q == 8'h01 && cnt_q < 6'h04;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_q <= 8'h03;
      sec_q <= 8'h01;
      cnt_q <= '0;
      step_q <= 1'b0;
      id_i <= '0;
    end else begin
      step_q <= step_o;
      if (step_o && !step_q)
        pos_q <= step_dir_o ? pos_q + 8'h01 : pos_q - 8'h01;
      cnt_q <= (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
      if (cnt_q == 6'h27)
        sec_q <= (sec_q == 8'h04) ? 8'h01 : sec_q + 8'h01;
      // idle lines show inverted values
      id_i <= '{v, v ? pos_q : ~pos_q, 1'b0, v ? sec_q : ~sec_q, 2'h1, v};
    end
  end
endmodule : dsss_drive_model
`default_nettype wire

// *** dv/dsss_top_bench.sv ***
// self-checking bench for the seek and sector search sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dsss_top_bench import dsss_pkg::*;;
  logic clock_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, st;
  logic master_reset_in, head_settled_in, track_zero_in, drive_ready_i;
  logic index_i, head_engage_out, step_o, step_dir_o, side_output_pin;
  logic inner_track_out, interrupt_request, data_done_i, data_go_o;
  logic trk0_stuck_i;
  logic [10:0] sector_bytes_o;
  dsss_id_s id_i;
  int fail_count, samples_checked;
  dsss_top #(.SETTLE_CYCLES(20), .RATE0_CYCLES(10), .RATE1_CYCLES(12),
    .RATE2_CYCLES(14), .RATE3_CYCLES(16)) uut (.*);
  dsss_drive_model drv (.*);
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic print_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask : bus
  task automatic wirq;
    int n;
    for (n = 0; n < 30000 && interrupt_request !== 1'b1; n++)
      @(posedge clock_i);
    if (n >= 30000) begin
      fail_count++;
      print_verdict();
    end
  endtask : wirq
  // wait for the data field start, then report it finished
  task automatic xfer;
    int n;
    for (n = 0; n < 2000 && data_go_o !== 1'b1; n++) @(posedge clock_i);
    if (n >= 2000) begin
      fail_count++;
      print_verdict();
    end
    `CHK("data go", 1'b1, data_go_o)
    data_done_i <= 1'b1;
    @(posedge clock_i);
    data_done_i <= 1'b0;
  endtask : xfer
  // command, wait for completion, read status and track
  task automatic op(input logic [7:0] c, output logic [31:0] t);
    bus(1'b1, REG_CMD, {24'h0, c}, t);
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    bus(1'b0, REG_TRACK, 32'h0, t);
  endtask : op
  task automatic t_restore;
    logic [31:0] t;
    @(posedge clock_i);
    master_reset_in <= 1'b0;
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    bus(1'b0, REG_TRACK, 32'h0, t);
    `CHK("restore track", 32'h0, t)
    `CHK("restore trk0", 1'b1, st[ST_TRK0])
    `CHK("restore busy", 1'b0, st[ST_BUSY])
    `CHK("restore head", 1'b0, head_engage_out)
    `CHK("irq cleared", 1'b0, interrupt_request)
  endtask : t_restore
  task automatic t_steps;
    logic [31:0] t;
    op(8'h50, t);
    op(8'h50, t);
    `CHK("step in track", 32'h2, t)
    `CHK("step in dir", 1'b1, step_dir_o)
    op(8'h70, t);
    `CHK("step out track", 32'h1, t)
    op(8'h30, t);
    `CHK("step track", 32'h0, t)
    `CHK("step trk0", 1'b1, st[ST_TRK0])
    op(8'h00, t);
    `CHK("restore at zero", 32'h0, t)
  endtask : t_steps
  task automatic t_seek;
    logic [31:0] t;
    bus(1'b1, REG_DATA, 32'h5, t);
    op(8'h1c, t);
    `CHK("seek track", 32'h5, t)
    `CHK("seek head", 1'b1, head_engage_out)
    `CHK("verify ok", 1'b0, st[ST_SEEK])
  endtask : t_seek
  task automatic t_sector;
    logic [31:0] t;
    // sector register loaded before command
    bus(1'b1, REG_SECTOR, 32'h3, t);
    bus(1'b1, REG_CMD, 32'h80, t);
    xfer();
    `CHK("sector bytes", 11'h100, sector_bytes_o)
    `CHK("inner track", 1'b0, inner_track_out)
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    `CHK("sector busy", 1'b0, st[ST_BUSY])
    `CHK("sector rnf", 1'b0, st[ST_SEEK])
  endtask : t_sector
  task automatic t_mismatch;
    logic [31:0] t;
    op(8'h2c, t);
    `CHK("no update track", 32'h5, t)
    `CHK("seek error", 1'b1, st[ST_SEEK])
  endtask : t_mismatch
  task automatic t_idle;
    repeat (1900) @(posedge clock_i);
    `CHK("head held", 1'b1, head_engage_out)
    repeat (800) @(posedge clock_i);
    `CHK("head unload", 1'b0, head_engage_out)
  endtask : t_idle
  task automatic t_not_ready;
    logic [31:0] t;
    drive_ready_i <= 1'b0;
    bus(1'b1, REG_CMD, 32'h80, t);
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    `CHK("not ready", 1'b1, st[ST_NOTRDY])
    `CHK("not ready busy", 1'b0, st[ST_BUSY])
    drive_ready_i <= 1'b1;
  endtask : t_not_ready
  task automatic t_multi;
    logic [31:0] t;
    bus(1'b1, REG_CFG, 32'h104, t);
    bus(1'b1, REG_TRACK, 32'h6, t);
    bus(1'b1, REG_SECTOR, 32'h3, t);
    bus(1'b1, REG_CMD, 32'h92, t);
    xfer();
    `CHK("short table", 11'h200, sector_bytes_o)
    `CHK("side pin set", 1'b1, side_output_pin)
    xfer();
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    bus(1'b0, REG_SECTOR, 32'h0, t);
    `CHK("multi sector", 32'h5, t)
    `CHK("multi rnf", 1'b1, st[ST_SEEK])
  endtask : t_multi
  task automatic t_missing;
    logic [31:0] t;
    bus(1'b1, REG_SECTOR, 32'h9, t);
    bus(1'b1, REG_CMD, 32'h80, t);
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    `CHK("missing rnf", 1'b1, st[ST_SEEK])
    `CHK("side pin clear", 1'b0, side_output_pin)
  endtask : t_missing
  task automatic t_force;
    logic [31:0] t;
    bus(1'b1, REG_CMD, 32'h80, t);
    bus(1'b1, REG_CMD, 32'hd0, t);
    wirq();
    bus(1'b0, REG_CMD, 32'h0, st);
    `CHK("force busy", 1'b0, st[ST_BUSY])
    `CHK("force no rnf", 1'b0, st[ST_SEEK])
  endtask : t_force
  task automatic t_limit;
    logic [31:0] t;
    trk0_stuck_i <= 1'b1;
    op(8'h00, t);
    `CHK("restore limit", 1'b1, st[ST_SEEK])
    `CHK("limit busy", 1'b0, st[ST_BUSY])
    trk0_stuck_i <= 1'b0;
  endtask : t_limit
  initial begin
    fail_count = 0;
    samples_checked = 0;
    reset_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = '0;
    avs_writedata_i = '0;
    master_reset_in = 1'b1;
    drive_ready_i = 1'b1;
    data_done_i = 1'b0;
    trk0_stuck_i = 1'b0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_restore();
    t_steps();
    t_seek();
    t_sector();
    t_mismatch();
    t_idle();
    t_not_ready();
    t_multi();
    t_missing();
    t_force();
    t_limit();
    print_verdict();
  end
endmodule : dsss_top_bench
`default_nettype wire
